// *** test/ebc_bus_ctrl_test.sv ***
`timescale 1ns/10ps

module ebc_bus_ctrl_test;
  import ebc_pkg::*;
  localparam int PS = 2;
  logic clk, rst_n, psel, penable, pwrite, sync_ready_in, rdy_w, hold_w, strap_lo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] dma_w, dma_pin, dma_s;
  ebc_cyc_req_s req;
  logic pready, er, taken, done, ube_n, ube_oe, bit0, ap, lock, den_n, dir;
  logic xoe, boe, lcs_n, ucs_n, ack, ack_oe, ca, ca_oe, cb, cb_oe;
  logic async_ready_in, hold, strap;
  int n_fail, checked, n, c;

  ebc_bus_ctrl #(.PS_DIV(PS)) ebc_bus_ctrl_inst (.i_clk_sys(clk),
    .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(er), .i_cyc_req(req), .o_cyc_taken(taken),
    .o_cyc_done(done), .i_async_ready_in(async_ready_in), .i_sync_ready_in(sync_ready_in),
    .i_hold_req(hold), .i_dma_request_in(dma_pin), .o_dma_req_sync(dma_s),
    .i_addr_phase_strap_n(strap), .o_upper_byte_enable_n(ube_n),
    .o_upper_byte_enable_oe(ube_oe), .o_mux_bus_bit0(bit0),
    .o_addr_phase_en(ap), .o_status_pins_locked(lock),
    .o_xcvr_output_enable_n(den_n), .o_xcvr_direction(dir), .o_xcvr_oe(xoe),
    .o_bus_oe(boe), .o_lower_mem_select_n(lcs_n),
    .o_upper_mem_select_n(ucs_n), .o_bus_grant_ack(ack),
    .o_bus_grant_ack_oe(ack_oe), .o_clk_out_primary(ca),
    .o_clk_out_primary_oe(ca_oe), .o_clk_out_secondary(cb),
    .o_clk_out_secondary_oe(cb_oe));

  ebc_far_model ebc_far_model_inst (.i_clk_sys(clk), .i_ready_want(rdy_w),
    .i_hold_want(hold_w), .i_dma_want(dma_w), .i_strap_low(strap_lo),
    .i_bus_grant_ack(ack), .i_upper_byte_enable_n(ube_n),
    .i_upper_byte_enable_oe(ube_oe), .o_async_ready_in(async_ready_in),
    .o_hold_req(hold), .o_dma_request_in(dma_pin), .o_strap_pin(strap));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic summarize();
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    c = er;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts output clock transitions over w falling edges
  task automatic toggles(input logic sel, input int w);
    logic v;
    c = 0;
    @(negedge clk);
    v = sel ? cb : ca;
    repeat (w)
    begin
      @(negedge clk);
      if ((sel ? cb : ca) !== v) c++;
      v = sel ? cb : ca;
    end
  endtask : toggles

  task automatic reset_dut(input logic sl);
    @(posedge clk);
    rst_n <= 1'b0;
    strap_lo <= sl;
    toggles(0, 3);
    chk("clk_in_reset", 3, c);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : reset_dut

  task automatic cyc(input ebc_kind_e kd, input ebc_lane_e ln,
    input ebc_region_e rg, input logic w, input logic hw, input int ra);
    logic [1:0] code;
    logic held;
    logic ackd;
    int k;
    code = (kd == KIND_RFSH) ? 2'h3 : ln;
    held = 1'b1;
    ackd = 1'b0;
    k = 0;
    @(posedge clk);
    req <= '{1'b1, kd, ln, rg, w, 1'b0};
    hold_w <= hw;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (taken !== 1'b1 && k < 60);
    chk("taken", 1, taken);
    @(posedge clk);
    req.valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      ackd = ackd | ack;
      if (n == ra) rdy_w <= 1'b1;
      if (n == 1) chk("lane_code", code, {ube_n, bit0});
      if (n == 1) chk("direction", w, dir);
      if (n == 1) chk("selects", {!(kd == KIND_MEM && rg == REG_LOWER),
        !(kd == KIND_MEM && rg == REG_UPPER)}, {lcs_n, ucs_n});
      if (n == 2) chk("xcvr_enable_n", kd == KIND_RFSH, den_n);
      if (n < 4 && ube_n !== code[1]) held = 1'b0;
    end
    while (done !== 1'b1 && n < 60);
    chk("cyc_done", 1, done);
    chk("ube_held", 1, held);
    chk("grant_in_cycle", 0, ackd);
  endtask : cyc

  task automatic wait_ack(input logic e, input int b);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end
    while (ack !== e && c < b);
    chk("grant_ack", e, ack);
  endtask : wait_ack

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, sync_ready_in, hold_w, strap_lo} = 6'h00;
    {paddr, pwdata, dma_w, req} = '0;
    rdy_w = 1'b1;
    n_fail = 0;
    checked = 0;
    reset_dut(0);
    chk("idle_selects", 2'h3, {lcs_n, ucs_n});
    apb(0, 8'h00, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(0, 8'h04, 32'h0);
    chk("strap_done", 2'h3, rd[1:0]);
    apb(0, 8'h08, 32'h0);
    chk("unmapped_err", 1, c);
    chk("unmapped_rd", 0, rd);
    for (int i = 0; i < 4; i++)
    begin
      cyc(i == 3 ? KIND_RFSH : KIND_MEM, ebc_lane_e'(i % 3), REG_OTHER,
          i[0], 0, 0);
      chk("cycle_len", 5, n);
    end
    @(posedge clk);
    rdy_w <= 1'b0;
    repeat (4) @(posedge clk);
    cyc(KIND_IO, LANE_WORD, REG_OTHER, 0, 0, 6);
    chk("wait_len", 1, n > 8);
    cyc(KIND_INTA, LANE_LOW, REG_OTHER, 1, 1, 0);
    wait_ack(1, 12);
    chk("hold_float", 3'h0, {boe, ube_oe, xoe});
    chk("hold_selects", 2'h3, {lcs_n, ucs_n});
    toggles(0, 4);
    chk("clk_in_hold", 4, c);
    cyc(KIND_RFSH, LANE_WORD, REG_OTHER, 0, 1, 0);
    chk("refresh_over_hold", 5, n);
    cyc(KIND_MEM, LANE_WORD, REG_OTHER, 0, 0, 0);
    hold_w <= 1'b1;
    wait_ack(1, 12);
    @(posedge clk);
    hold_w <= 1'b0;
    wait_ack(0, 6);
    // A locked cycle lets the queued request run ahead of a pending hold
    @(posedge clk);
    req <= '{1'b1, KIND_MEM, LANE_WORD, REG_OTHER, 1'b0, 1'b1};
    hold_w <= 1'b1;
    cyc(KIND_MEM, LANE_HIGH, REG_OTHER, 0, 1, 0);
    wait_ack(1, 12);
    @(posedge clk);
    hold_w <= 1'b0;
    wait_ack(0, 6);
    apb(1, 8'h00, 32'h10);
    cyc(KIND_MEM, LANE_WORD, REG_LOWER, 0, 0, 0);
    chk("lower_disabled", 0, ap);
    cyc(KIND_MEM, LANE_WORD, REG_UPPER, 0, 0, 0);
    chk("upper_enabled", 1, ap);
    reset_dut(1);
    chk("locked", 1, lock);
    apb(1, 8'h00, 32'h30);
    cyc(KIND_MEM, LANE_WORD, REG_LOWER, 1, 0, 0);
    chk("strap_low_addr", 1, ap);
    strap_lo <= 1'b0;
    repeat (6) @(posedge clk);
    apb(0, 8'h04, 32'h0);
    chk("mode_kept", 2'h2, {lock, rd[0]});
    reset_dut(0);
    for (int m = 0; m < 3; m++)
    begin
      apb(1, 8'h00, 32'(m * 5));
      repeat (2) @(negedge clk);
      chk("clk_oe", {2{m < 2}}, {ca_oe, cb_oe});
      toggles(0, 8);
      if (m < 2) chk("clk_a_rate", m ? 8 / PS : 8, c);
      toggles(1, 8);
      if (m < 2) chk("clk_b_rate", m ? 8 / PS : 8, c);
    end
    apb(1, 8'h00, 32'h40);
    repeat (2) @(negedge clk);
    chk("iso_float", 2'h0, {ack_oe, ube_oe});
    @(posedge clk);
    dma_w <= 2'h2;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("dma_early", 2'h0, dma_s);
    @(negedge clk);
    chk("dma_sync", 2'h2, dma_s);
    summarize();
  end
endmodule : ebc_bus_ctrl_test

// *** test/ebc_far_model.sv ***
`timescale 1ns/10ps

// Far side: ready source, bus master, DMA requester and strap pull-up
module ebc_far_model
(
  input wire logic i_clk_sys,
  input wire logic i_ready_want,
  input wire logic i_hold_want,
  input wire logic [1:0] i_dma_want,
  input wire logic i_strap_low,
  input wire logic i_bus_grant_ack,
  input wire logic i_upper_byte_enable_n,
  input wire logic i_upper_byte_enable_oe,
  output logic o_async_ready_in,
  output logic o_hold_req,
  output logic [1:0] o_dma_request_in,
  output wire logic o_strap_pin
);
  logic ack_seen_ff = 1'b0;
  logic yielded_ff = 1'b0;
  logic yield;
  initial o_async_ready_in = 1'b1;
  initial o_hold_req = 1'b0;
  initial o_dma_request_in = 2'h0;
  // Falls only on a clock edge, never in mid-cycle
  always @(posedge i_clk_sys) o_async_ready_in <= i_ready_want;
  // Device keeps no copy, so the request stays while wanted
  always @(posedge i_clk_sys) o_dma_request_in <= i_dma_want;
  // Acknowledge lost while still asking: device wants the bus back
  assign yield = ack_seen_ff & ~i_bus_grant_ack & o_hold_req;
  always @(posedge i_clk_sys)
  begin
    ack_seen_ff <= o_hold_req & i_bus_grant_ack;
    yielded_ff <= i_hold_want & (yielded_ff | yield);
    o_hold_req <= i_hold_want & ~yielded_ff & ~yield;
  end
  // Weak pull-up wins when nobody drives the shared pin, unless it is strapped low
  assign o_strap_pin = i_upper_byte_enable_oe ? i_upper_byte_enable_n
                                              : ~i_strap_low;
endmodule : ebc_far_model

// *** verilog/ebc_bus_ctrl.sv ***
`timescale 1ns/10ps
`include "ebc_map.svh"

module ebc_bus_ctrl
  import ebc_pkg::*;
#(
  parameter int PS_DIV = `EBC_PS_DIV
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`EBC_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire ebc_cyc_req_s i_cyc_req,
  output logic o_cyc_taken,
  output logic o_cyc_done,
  input wire logic i_async_ready_in,
  input wire logic i_sync_ready_in,
  input wire logic i_hold_req,
  input wire logic [1:0] i_dma_request_in,
  output logic [1:0] o_dma_req_sync,
  input wire logic i_addr_phase_strap_n,
  output logic o_upper_byte_enable_n,
  output logic o_upper_byte_enable_oe,
  output logic o_mux_bus_bit0,
  output logic o_addr_phase_en,
  output logic o_status_pins_locked,
  output logic o_xcvr_output_enable_n,
  output logic o_xcvr_direction,
  output logic o_xcvr_oe,
  output logic o_bus_oe,
  output logic o_lower_mem_select_n,
  output logic o_upper_mem_select_n,
  output logic o_bus_grant_ack,
  output logic o_bus_grant_ack_oe,
  output logic o_clk_out_primary,
  output logic o_clk_out_primary_oe,
  output logic o_clk_out_secondary,
  output logic o_clk_out_secondary_oe
);

  function automatic logic clk_pick(input logic [1:0] mode,
                                    input logic fund,
                                    input logic psave);
    clk_pick = (mode == CLK_PSAVE) ? psave : fund;
  endfunction : clk_pick

  function automatic logic in_hold(input ebc_state_e st);
    in_hold = (st == ST_HOLD) || (st == ST_HEXIT);
  endfunction : in_hold

  logic async_ready_in_q;
  logic sync_ready_in_q;
  logic hold_q;
  logic strap_q;
  logic [1:0] dma_q;
  logic ready_ok;
  logic refresh_pend;
  logic ctrl_hit;
  logic stat_hit;
  logic [31:0] stat_word;
  logic [`EBC_CTRL_W-1:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  logic strap_en_ff;
  logic lock_ff;
  ebc_state_e state_ff;
  ebc_state_e nxt_state;
  ebc_cyc_req_s cur_ff;
  logic ack_ff;
  logic ube_n_ff;
  logic bit0_ff;
  logic ube_oe_ff;
  logic aphase_ff;
  logic den_n_ff;
  logic dir_ff;
  logic drv_ff;
  logic lcs_n_ff;
  logic ucs_n_ff;
  logic done_ff;
  // Clocks run straight through reset, so they carry power-up values
  // rather than a reset branch that would stop them.
  logic fund_tog_ff = 1'b0;
  logic ps_tog_ff = 1'b0;
  logic [15:0] ps_cnt_ff = 16'h0000;
  logic clka_ff = 1'b0;
  logic clkb_ff = 1'b0;

  ebc_sync #(.W(6)) u_sync
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_d({i_async_ready_in, i_sync_ready_in, i_hold_req,
          i_addr_phase_strap_n, i_dma_request_in}),
    .o_q({async_ready_in_q, sync_ready_in_q, hold_q, strap_q, dma_q})
  );

  // Either ready ends the wait; a grounded async ready defers to the other
  assign ready_ok = async_ready_in_q | sync_ready_in_q;
  assign o_dma_req_sync = dma_q;
  assign refresh_pend = i_cyc_req.valid && (i_cyc_req.kind == KIND_RFSH);

  // APB slave, zero wait states
  assign ctrl_hit = (i_paddr == `EBC_OFS_CTRL);
  assign stat_hit = (i_paddr == `EBC_OFS_STAT);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !ctrl_hit && !stat_hit;
  assign o_prdata = prdata_ff;

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`EBC_B_STRAP] = strap_en_ff;
    stat_word[`EBC_B_DONE] = strap_done_ff;
    stat_word[`EBC_B_ACK] = ack_ff;
    stat_word[`EBC_B_HOLD] = hold_q;
    stat_word[`EBC_F_DMA] = dma_q;
    stat_word[`EBC_B_RDY] = ready_ok;
    stat_word[`EBC_B_BUSY] = (state_ff != ST_IDLE);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      ctrl_ff <= `EBC_CTRL_RST;
    else if (i_psel && i_penable && i_pwrite && ctrl_hit)
      ctrl_ff <= i_pwdata[`EBC_CTRL_W-1:0];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      prdata_ff <= 32'h0000_0000;
    else if (i_psel && !i_penable)
    begin
      if (ctrl_hit)
        prdata_ff <= {{(32-`EBC_CTRL_W){1'b0}}, ctrl_ff};
      else if (stat_hit)
        prdata_ff <= stat_word;
      else
        prdata_ff <= 32'h0000_0000;
    end
  end

  // Strap capture: once per reset, never writable
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strap_en_ff <= `EBC_STRAP_RST;
    end
    else if (!strap_done_ff)
    begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `EBC_STRAP_CYC)
      begin
        strap_done_ff <= 1'b1;
        strap_en_ff <= strap_q;
      end
    end
  end

  assign o_status_pins_locked = strap_done_ff && !strap_en_ff;

  // Bus cycle sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (refresh_pend)
          nxt_state = ST_T1;
        else if (lock_ff && i_cyc_req.valid)
          nxt_state = ST_T1;
        else if (hold_q)
          nxt_state = ST_HOLD;
        else if (i_cyc_req.valid)
          nxt_state = ST_T1;
      end
      ST_T1: nxt_state = ST_T2;
      ST_T2: nxt_state = ST_T3;
      ST_T3, ST_TW: nxt_state = ready_ok ? ST_T4 : ST_TW;
      ST_T4: nxt_state = ST_IDLE;
      ST_HOLD:
      begin
        if (!hold_q)
          nxt_state = ST_IDLE;
        else if (refresh_pend)
          nxt_state = ST_HEXIT;
      end
      ST_HEXIT: nxt_state = hold_q ? ST_HEXIT : ST_IDLE;
    endcase
  end

  assign o_cyc_taken = (state_ff == ST_IDLE) && (nxt_state == ST_T1);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_IDLE;
      ack_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ack_ff <= (nxt_state == ST_HOLD);
      done_ff <= (state_ff == ST_T4);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cur_ff <= '0;
      lock_ff <= 1'b0;
    end
    else if (o_cyc_taken)
    begin
      cur_ff <= i_cyc_req;
      lock_ff <= i_cyc_req.lock;
    end
  end

  // Pin drivers, registered from the next state
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      ube_n_ff <= 1'b1;
      bit0_ff <= 1'b1;
      ube_oe_ff <= 1'b0;
      aphase_ff <= 1'b1;
      drv_ff <= 1'b0;
    end
    else
    begin
      ube_oe_ff <= !in_hold(nxt_state) && !ctrl_ff[`EBC_B_ISO];
      drv_ff <= !in_hold(nxt_state);
      if (o_cyc_taken)
      begin
        // Refresh gets 11; the nonmux bit 0 is never the flag
        if (i_cyc_req.kind == KIND_RFSH)
          {ube_n_ff, bit0_ff} <= 2'b11;
        else
          {ube_n_ff, bit0_ff} <= i_cyc_req.lane;
        if (!strap_en_ff)
          aphase_ff <= 1'b1;
        else if (i_cyc_req.region == REG_LOWER)
          aphase_ff <= !ctrl_ff[`EBC_B_DA_LO];
        else if (i_cyc_req.region == REG_UPPER)
          aphase_ff <= !ctrl_ff[`EBC_B_DA_UP];
        else
          aphase_ff <= 1'b1;
      end
    end
  end

  // Direction moves only at T1, while the enable is already off
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      den_n_ff <= 1'b1;
      dir_ff <= 1'b0;
    end
    else
    begin
      if (o_cyc_taken)
        dir_ff <= i_cyc_req.write;
      den_n_ff <= !(((nxt_state == ST_T2) || (nxt_state == ST_T3) ||
                     (nxt_state == ST_TW)) &&
                    (cur_ff.kind != KIND_RFSH));
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      lcs_n_ff <= 1'b1;
      ucs_n_ff <= 1'b1;
    end
    else
    begin
      lcs_n_ff <= !((o_cyc_taken && (i_cyc_req.kind == KIND_MEM) &&
                     (i_cyc_req.region == REG_LOWER)) ||
                    (!lcs_n_ff && (state_ff != ST_T4)));
      ucs_n_ff <= !((o_cyc_taken && (i_cyc_req.kind == KIND_MEM) &&
                     (i_cyc_req.region == REG_UPPER)) ||
                    (!ucs_n_ff && (state_ff != ST_T4)));
    end
  end

  assign o_upper_byte_enable_n = ube_n_ff;
  assign o_upper_byte_enable_oe = ube_oe_ff;
  assign o_mux_bus_bit0 = bit0_ff;
  assign o_addr_phase_en = aphase_ff;
  assign o_xcvr_output_enable_n = den_n_ff;
  assign o_xcvr_direction = dir_ff;
  assign o_xcvr_oe = drv_ff;
  assign o_bus_oe = drv_ff;
  assign o_lower_mem_select_n = lcs_n_ff;
  assign o_upper_mem_select_n = ucs_n_ff;
  assign o_bus_grant_ack = ack_ff;
  assign o_bus_grant_ack_oe = !ctrl_ff[`EBC_B_ISO];
  assign o_cyc_done = done_ff;

  // Clock generation; no reset branch so the clocks keep running
  always_ff @(posedge i_clk_sys)
  begin
    fund_tog_ff <= !fund_tog_ff;
    if (ps_cnt_ff >= 16'(PS_DIV - 1))
    begin
      ps_cnt_ff <= 16'h0000;
      ps_tog_ff <= !ps_tog_ff;
    end
    else
      ps_cnt_ff <= ps_cnt_ff + 16'h0001;
  end

  always_ff @(posedge i_clk_sys)
  begin
    clka_ff <= clk_pick(ctrl_ff[`EBC_F_CLKA], fund_tog_ff, ps_tog_ff);
    clkb_ff <= clk_pick(ctrl_ff[`EBC_F_CLKB], fund_tog_ff, ps_tog_ff);
  end

  assign o_clk_out_primary = clka_ff;
  assign o_clk_out_secondary = clkb_ff;
  assign o_clk_out_primary_oe = !ctrl_ff[`EBC_B_CLKA_FLT];
  assign o_clk_out_secondary_oe = !ctrl_ff[`EBC_B_CLKB_FLT];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_hold_in;
    (state_ff == ST_HOLD) && hold_q && refresh_pend;
  endsequence

  sequence s_hold_out;
    !ack_ff ##1 (!ack_ff)[*2];
  endsequence

  property p_encode;
    o_cyc_taken && (i_cyc_req.kind == KIND_RFSH)
      |=> o_upper_byte_enable_n && o_mux_bus_bit0;
  endproperty
  a_encode: assert property (p_encode)
    else $error("refresh cycle not encoded as 11");

  property p_ube_float;
    in_hold(state_ff) |-> !o_upper_byte_enable_oe;
  endproperty
  a_ube_float: assert property (p_ube_float)
    else $error("byte enable driven during hold");

  property p_den_dir;
    $changed(o_xcvr_direction) |-> o_xcvr_output_enable_n;
  endproperty
  a_den_dir: assert property (p_den_dir)
    else $error("transceiver enabled while direction changes");

  property p_strap_time;
    $rose(i_rst_n) |-> ##[0:3] strap_done_ff;
  endproperty
  a_strap_time: assert property (p_strap_time)
    else $error("strap not sampled within three clocks");

  property p_strap_keep;
    strap_done_ff |=> $stable(strap_en_ff) && strap_done_ff;
  endproperty
  a_strap_keep: assert property (p_strap_keep)
    else $error("strap mode changed without reset");

  property p_wait;
    (state_ff == ST_T3) && !ready_ok |=> (state_ff == ST_TW);
  endproperty
  a_wait: assert property (p_wait)
    else $error("cycle ended without ready");

  property p_release;
    ack_ff && !hold_q |=> !ack_ff;
  endproperty
  a_release: assert property (p_release)
    else $error("acknowledge kept after request dropped");

  property p_reclaim;
    s_hold_in |=> s_hold_out;
  endproperty
  a_reclaim: assert property (p_reclaim)
    else $error("acknowledge not dropped for refresh");

  property p_cs_high;
    ack_ff |-> o_lower_mem_select_n && o_upper_mem_select_n && !o_bus_oe;
  endproperty
  a_cs_high: assert property (p_cs_high)
    else $error("selects low or bus driven in hold");

  property p_prio;
    (state_ff == ST_IDLE) && refresh_pend && hold_q |=> (state_ff == ST_T1);
  endproperty
  a_prio: assert property (p_prio)
    else $error("hold beat a pending refresh");

endmodule : ebc_bus_ctrl

// *** verilog/ebc_map.svh ***
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH

// APB register offsets (byte addresses)
`define EBC_ADDR_W 8
`define EBC_OFS_CTRL 8'h00
`define EBC_OFS_STAT 8'h04

// Control register layout
`define EBC_CTRL_W 7
`define EBC_CTRL_RST 7'h00
`define EBC_F_CLKA 1:0
`define EBC_F_CLKB 3:2
// Upper bit of each clock mode field: codes 10 and 11 float the pin
`define EBC_B_CLKA_FLT 1
`define EBC_B_CLKB_FLT 3
`define EBC_B_DA_LO 4
`define EBC_B_DA_UP 5
`define EBC_B_ISO 6

// Status register layout
`define EBC_B_STRAP 0
`define EBC_B_DONE 1
`define EBC_B_ACK 2
`define EBC_B_HOLD 3
`define EBC_F_DMA 5:4
`define EBC_B_RDY 6
`define EBC_B_BUSY 7

// Strap capture: cycle after reset release, must stay below three
`define EBC_STRAP_CYC 2'h2
`define EBC_STRAP_RST 1'b1

// Default half period of the power-save clock, in system clocks
`define EBC_PS_DIV 8

`endif

// *** verilog/ebc_pkg.sv ***
package ebc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_T1    = 3'b001,
    ST_T2    = 3'b010,
    ST_T3    = 3'b011,
    ST_TW    = 3'b100,
    ST_T4    = 3'b101,
    ST_HOLD  = 3'b110,
    ST_HEXIT = 3'b111
  } ebc_state_e;

  typedef enum logic [1:0] {
    KIND_MEM  = 2'b00,
    KIND_IO   = 2'b01,
    KIND_INTA = 2'b10,
    KIND_RFSH = 2'b11
  } ebc_kind_e;

  // Codes equal the {upper_byte_enable_n, mux_bus_bit0} pair
  typedef enum logic [1:0] {
    LANE_WORD = 2'b00,
    LANE_HIGH = 2'b01,
    LANE_LOW  = 2'b10,
    LANE_NONE = 2'b11
  } ebc_lane_e;

  typedef enum logic [1:0] {
    REG_LOWER = 2'b00,
    REG_UPPER = 2'b01,
    REG_OTHER = 2'b10,
    REG_NONE  = 2'b11
  } ebc_region_e;

  typedef enum logic [1:0] {
    CLK_FUND  = 2'b00,
    CLK_PSAVE = 2'b01,
    CLK_FLOAT = 2'b10,
    CLK_OFF   = 2'b11
  } ebc_clk_mode_e;

  typedef struct packed {
    logic valid;
    ebc_kind_e kind;
    ebc_lane_e lane;
    ebc_region_e region;
    logic write;
    logic lock;
  } ebc_cyc_req_s;

endpackage : ebc_pkg

// *** verilog/ebc_sync.sv ***
`timescale 1ns/10ps

// Two-stage synchroniser; only the second stage leaves this module
module ebc_sync
#(
  parameter int W = 1
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end

  assign o_q = q_ff;

endmodule : ebc_sync
